// ==== rtl/flash_host_pkg.sv ====
// Constants, command codes and carrier types for the flash erase and status host.
// Assumes a single 10 MHz core clock and an asynchronous parallel flash on the pins.
package flash_host_pkg;

	// ----------------------------------------------------------------------
	// Clock and pin timing.
	// ----------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100; // Core clock period.
	localparam int unsigned RESET_PULSE_MIN_NS = 500; // Least reset low time.
	localparam int unsigned RESET_HIGH_BEFORE_READ_NS = 50; // Least high time before a read.
	localparam int unsigned UNPROTECT_RESET_SETUP_NS = 4000; // Elevated reset before first write.
	localparam int unsigned PROTECT_PULSE_WIDTH_NS = 10000; // Protect write pulse, typical.
	localparam int unsigned UNPROTECT_PULSE_WIDTH_NS = 12000000; // Unprotect pulse, typical.
	localparam int unsigned PULSE_MIN_NS = 100; // Least high-voltage write pulse.
	localparam int unsigned READY_ALGO_NS = 20000; // Longest recovery, algorithm running.
	localparam int unsigned READY_IDLE_NS = 500; // Longest recovery, no algorithm.

	localparam int unsigned CNT_W = 17; // Width of the shared cycle counter.
	typedef logic [CNT_W-1:0] cnt_t; // Cycle count type.

	// Least times round up, longest times round down, none below one cycle.
	localparam cnt_t RST_PULSE_CYC = cnt_t'((RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t RST_HIGH_CYC = cnt_t'((RESET_HIGH_BEFORE_READ_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam cnt_t ELEV_SETUP_CYC = cnt_t'((UNPROTECT_RESET_SETUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam cnt_t PROT_PULSE_CYC = cnt_t'((PROTECT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam int unsigned UNPROT_PULSE_CYC_DEF = (UNPROTECT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam cnt_t PULSE_MIN_CYC = cnt_t'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam cnt_t READY_ALGO_CYC = cnt_t'(READY_ALGO_NS / CLK_PERIOD_NS);
	localparam cnt_t READY_IDLE_CYC = cnt_t'(READY_IDLE_NS / CLK_PERIOD_NS);
	localparam cnt_t RD_HOLD_CYC = cnt_t'(5); // Read strobe length, covers the input filter.

	// ----------------------------------------------------------------------
	// Bus layout and erase command sequence.
	// ----------------------------------------------------------------------
	localparam int unsigned ADDR_W = 18; // Word address width.
	localparam int unsigned DATA_W = 16; // Data bus width.
	localparam int unsigned SECTOR_SELECT_LOW_BIT = 12; // Lowest sector select bit.
	localparam int unsigned SECTOR_SELECT_HIGH_BIT = 17; // Highest sector select bit.
	localparam int unsigned POLL_STATUS_BIT = 7; // Reads 0 while erasing, 1 when done.
	localparam int unsigned TOGGLE_STATUS_BIT = 6; // Inverts on each read while busy.
	localparam logic [2:0] ERASE_LAST_STEP = 3'h5; // Six bus writes per sector erase.
	localparam logic [5:0][ADDR_W-1:0] ERASE_ADDR = {18'h00000, 18'h002aa, 18'h00555,
		18'h00555, 18'h002aa, 18'h00555};
	localparam logic [5:0][DATA_W-1:0] ERASE_DATA = {16'h0030, 16'h0055, 16'h00aa,
		16'h0080, 16'h0055, 16'h00aa};
	localparam logic [ADDR_W-1:0] TOGGLE_ADDR = 18'h00000; // Any address serves for toggling.
	localparam logic [5:0] ELEV_AGE_MAX = 6'h3f; // Saturation of the elevated-level age counter.

	// ----------------------------------------------------------------------
	// Commands, states and carriers.
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_ERASE = 3'h0,
		OP_RESET = 3'h1,
		OP_TEMP_ENTER = 3'h2,
		OP_TEMP_EXIT = 3'h3,
		OP_PROTECT = 3'h4,
		OP_UNPROTECT = 3'h5
	} op_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_WR_LOW = 4'h1,
		ST_WR_HIGH = 4'h2,
		ST_RD = 4'h3,
		ST_CHECK = 4'h4,
		ST_RST_LOW = 4'h5,
		ST_RST_WAIT = 4'h6,
		ST_ELEV_SETUP = 4'h7,
		ST_HV_SETUP = 4'h8,
		ST_HV_PULSE = 4'h9,
		ST_HV_END = 4'ha
	} state_e;

	typedef struct packed {
		op_e op; // Operation to run.
		logic [5:0] sector; // Sector select value.
		logic use_toggle; // 1 selects toggle checking, 0 data polling.
	} cmd_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr; // Address pins.
		logic [DATA_W-1:0] dq_out; // Data pins, driven value.
		logic dq_oe_n; // Low while the host drives the data pins.
		logic ce_n; // Chip enable, active low.
		logic oe_n; // Output enable, active low.
		logic we_n; // Write enable, active low.
		logic reset_n; // Reset pin, active low.
		logic reset_hv; // Raises the reset pin to the elevated voltage level.
		logic prot_line_hv; // Raises the protect voltage line to the elevated level.
	} flash_pins_s;

	localparam flash_pins_s PINS_IDLE = '{addr: 18'h00000, dq_out: 16'h0000, dq_oe_n: 1'b1,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, reset_hv: 1'b0, prot_line_hv: 1'b0};

endpackage : flash_host_pkg

// ==== rtl/flash_in_sync.sv ====
// Three-stage input filter for pins that come from outside the clock domain.
// Assumes the inputs are asynchronous; output follows once stages two and three agree.
module flash_in_sync #(
	parameter int unsigned W = 1
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// ----------------------------------------------------------------------
	// Stages.
	// ----------------------------------------------------------------------
	logic [W-1:0] s1_q; // First stage, read only by the second.
	logic [W-1:0] s2_q; // Second stage.
	logic [W-1:0] s3_q; // Third stage.
	logic [W-1:0] q_q; // Accepted value.
	logic [W-1:0] q_d; // Next accepted value.

	// A bit counts as changed once the second and third stages agree on it.
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	// Registers of the filter.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q <= '0;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q <= q_d;
		end
	end

	assign q_o = q_q;

endmodule : flash_in_sync

// ==== rtl/flash_erase_host.sv ====
// Host controller that starts sector erases on a parallel flash, watches status,
// pulses the reset pin and runs the sector protect and unprotect pin procedures.
// Assumes one 10 MHz clock; flash pins are asynchronous and filtered on the way in.
//
// Summary of operation
// - Completion found by polling or toggle reads.
// - Toggle reads any address; polling valid address.
// - Hold reset low at least 500 ns.
// - Keep reset high 50 ns before read.
// - Elevated reset held 4 us before write.
// - Protect write pulse at least 100 ns.
// - Unprotect write pulse at least 100 ns.
module flash_erase_host #(
	parameter int unsigned UNPROT_PULSE_CYC = flash_host_pkg::UNPROT_PULSE_CYC_DEF
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic cmd_valid_i,
	input wire flash_host_pkg::cmd_s cmd_i,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
	input wire logic algorithm_done_output_i,
	output flash_host_pkg::flash_pins_s flash_o,
	output logic busy_o,
	output logic done_o,
	output logic [flash_host_pkg::DATA_W-1:0] status_o,
	output logic ready_o
);
	import flash_host_pkg::*;

	// ----------------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------------
	state_e state_q, state_d; // Sequencer state.
	cnt_t cnt_q, cnt_d; // Shared cycle counter.
	cnt_t wait_q, wait_d; // Length of the current timed wait.
	logic [2:0] step_q, step_d; // Erase write index.
	cmd_s cmd_q, cmd_d; // Command being run.
	logic [DATA_W-1:0] stat_q, stat_d; // Latest status read.
	logic [DATA_W-1:0] prev_q, prev_d; // Status read before the latest.
	logic have_prev_q, have_prev_d; // A toggle reference has been taken.
	logic algo_q, algo_d; // An erase algorithm is believed running.
	flash_pins_s pins_q, pins_d; // Registered pin values.
	logic busy_q, busy_d; // Sequencer busy.
	logic done_q, done_d; // One-cycle completion pulse.
	logic [DATA_W-1:0] dq_f; // Filtered data pins.
	logic rb_f; // Filtered ready/busy pin, high when ready.
	cnt_t unprot_cyc; // Unprotect pulse length in cycles.

	assign unprot_cyc = cnt_t'(UNPROT_PULSE_CYC);

	// Data and ready/busy pins come from the flash and pass the input filter.
	flash_in_sync #(
		.W(DATA_W + 1)
	) u_in_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.d_i({algorithm_done_output_i, dq_i}),
		.q_o({rb_f, dq_f})
	);

	// ----------------------------------------------------------------------
	// Sequencer next state.
	// ----------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		wait_d = wait_q;
		step_d = step_q;
		cmd_d = cmd_q;
		stat_d = stat_q;
		prev_d = prev_q;
		have_prev_d = have_prev_q;
		algo_d = algo_q;
		pins_d = pins_q;
		done_d = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				// A command is taken only while idle.
				if (cmd_valid_i)
				begin
					cmd_d = cmd_i;
					cnt_d = '0;
					step_d = 3'h0;
					have_prev_d = 1'b0;
					case (cmd_i.op)
						OP_ERASE:
						begin
							// First unlock write; sector goes on the last one.
							pins_d.addr = ERASE_ADDR[0];
							pins_d.dq_out = ERASE_DATA[0];
							pins_d.dq_oe_n = 1'b0;
							pins_d.ce_n = 1'b0;
							pins_d.we_n = 1'b0;
							state_d = ST_WR_LOW;
						end
						OP_RESET:
						begin
							// Reset pin low; a running algorithm needs the long recovery.
							pins_d.reset_n = 1'b0;
							pins_d.reset_hv = 1'b0;
							wait_d = (algo_q || !rb_f) ? READY_ALGO_CYC : READY_IDLE_CYC;
							state_d = ST_RST_LOW;
						end
						OP_TEMP_ENTER:
						begin
							// Reset pin goes to the elevated level before any write.
							pins_d.reset_hv = 1'b1;
							state_d = ST_ELEV_SETUP;
						end
						OP_TEMP_EXIT:
						begin
							// Leave the elevated level and let the pin settle.
							pins_d.reset_hv = 1'b0;
							wait_d = READY_IDLE_CYC;
							state_d = ST_RST_WAIT;
						end
						OP_PROTECT, OP_UNPROTECT:
						begin
							// Protect line to elevated level, sector on the address pins.
							pins_d.prot_line_hv = 1'b1;
							pins_d.ce_n = 1'b0;
							pins_d.addr = {cmd_i.sector, 12'h000};
							state_d = ST_HV_SETUP;
						end
						default:
						begin
							// Unknown operations complete at once.
							done_d = 1'b1;
						end
					endcase
				end
			end
			ST_WR_LOW:
			begin
				// Write strobe ends; data and chip enable release together.
				pins_d.we_n = 1'b1;
				pins_d.ce_n = 1'b1;
				pins_d.dq_oe_n = 1'b1;
				state_d = ST_WR_HIGH;
			end
			ST_WR_HIGH:
			begin
				if (step_q == ERASE_LAST_STEP)
				begin
					// Erase has started; begin status reads.
					algo_d = 1'b1;
					pins_d.ce_n = 1'b0;
					pins_d.oe_n = 1'b0;
					pins_d.addr = cmd_q.use_toggle ? TOGGLE_ADDR
						: {cmd_q.sector, 12'h000};
					cnt_d = '0;
					state_d = ST_RD;
				end
				else
				begin
					// Next write of the sequence; the last one carries the sector.
					step_d = step_q + 3'h1;
					pins_d.addr = (step_q + 3'h1 == ERASE_LAST_STEP)
						? {cmd_q.sector, 12'h000} : ERASE_ADDR[step_q + 3'h1];
					pins_d.dq_out = ERASE_DATA[step_q + 3'h1];
					pins_d.dq_oe_n = 1'b0;
					pins_d.ce_n = 1'b0;
					pins_d.we_n = 1'b0;
					state_d = ST_WR_LOW;
				end
			end
			ST_RD:
			begin
				// Hold the read strobe until the filtered data has settled.
				if (cnt_q == RD_HOLD_CYC - cnt_t'(1))
				begin
					stat_d = dq_f;
					pins_d.oe_n = 1'b1;
					pins_d.ce_n = 1'b1;
					state_d = ST_CHECK;
				end
				else
				begin
					cnt_d = cnt_q + cnt_t'(1);
				end
			end
			ST_CHECK:
			begin
				// Decide completion from the latest status read.
				if (!cmd_q.use_toggle && stat_q[POLL_STATUS_BIT])
				begin
					algo_d = 1'b0;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
				else if (cmd_q.use_toggle && have_prev_q
					&& (stat_q[TOGGLE_STATUS_BIT] == prev_q[TOGGLE_STATUS_BIT]))
				begin
					algo_d = 1'b0;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
				else
				begin
					// Still busy: keep a toggle reference and read again.
					prev_d = stat_q;
					have_prev_d = 1'b1;
					pins_d.ce_n = 1'b0;
					pins_d.oe_n = 1'b0;
					cnt_d = '0;
					state_d = ST_RD;
				end
			end
			ST_RST_LOW:
			begin
				// Reset pin stays low for its least pulse width.
				if (cnt_q == RST_PULSE_CYC - cnt_t'(1))
				begin
					pins_d = PINS_IDLE;
					cnt_d = '0;
					algo_d = 1'b0;
					state_d = ST_RST_WAIT;
				end
				else
				begin
					cnt_d = cnt_q + cnt_t'(1);
				end
			end
			ST_RST_WAIT:
			begin
				// Wait for the device to recover; never shorter than the high time.
				if ((cnt_q >= wait_q - cnt_t'(1)) && (cnt_q >= RST_HIGH_CYC))
				begin
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
				else
				begin
					cnt_d = cnt_q + cnt_t'(1);
				end
			end
			ST_ELEV_SETUP:
			begin
				// Elevated reset stands its setup time before the command ends.
				if (cnt_q == ELEV_SETUP_CYC - cnt_t'(1))
				begin
					done_d = 1'b1;
					state_d = ST_IDLE;
				end
				else
				begin
					cnt_d = cnt_q + cnt_t'(1);
				end
			end
			ST_HV_SETUP:
			begin
				// Start the write pulse of the protect or unprotect procedure.
				pins_d.we_n = 1'b0;
				cnt_d = '0;
				state_d = ST_HV_PULSE;
			end
			ST_HV_PULSE:
			begin
				// Protect pulse is the typical figure, unprotect lasts UNPROT_PULSE_CYC; both well above the least width.
				if (cnt_q == ((cmd_q.op == OP_PROTECT) ? PROT_PULSE_CYC : unprot_cyc)
					- cnt_t'(1))
				begin
					pins_d.we_n = 1'b1;
					state_d = ST_HV_END;
				end
				else
				begin
					cnt_d = cnt_q + cnt_t'(1);
				end
			end
			ST_HV_END:
			begin
				// Drop the elevated level after the pulse has ended.
				pins_d.prot_line_hv = 1'b0;
				pins_d.ce_n = 1'b1;
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default:
			begin
				pins_d = PINS_IDLE;
				state_d = ST_IDLE;
			end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	// Registers of the sequencer.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			wait_q <= '0;
			step_q <= 3'h0;
			cmd_q <= '0;
			stat_q <= '0;
			prev_q <= '0;
			have_prev_q <= 1'b0;
			algo_q <= 1'b0;
			pins_q <= PINS_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			wait_q <= wait_d;
			step_q <= step_d;
			cmd_q <= cmd_d;
			stat_q <= stat_d;
			prev_q <= prev_d;
			have_prev_q <= have_prev_d;
			algo_q <= algo_d;
			pins_q <= pins_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign flash_o = pins_q;
	assign busy_o = busy_q;
	assign done_o = done_q;
	assign status_o = stat_q;
	assign ready_o = rb_f;

	// ----------------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------------
	logic [5:0] elev_age_q; // Cycles the reset pin has stood at the elevated level.
	cnt_t wlen_q; // Cycles the write strobe has stood low.

	// Helper counters for pulse and setup checks.
	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			elev_age_q <= 6'h00;
			wlen_q <= '0;
		end
		else
		begin
			elev_age_q <= !pins_q.reset_hv ? 6'h00
				: ((elev_age_q == ELEV_AGE_MAX) ? elev_age_q : elev_age_q + 6'h01);
			wlen_q <= pins_q.we_n ? '0 : wlen_q + cnt_t'(1);
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_reset_low_hold;
		!pins_q.reset_n [*5];
	endsequence

	sequence s_no_read_after_release;
		pins_q.oe_n ##1 pins_q.oe_n;
	endsequence

	a_reset_pulse_width: assert property ($fell(pins_q.reset_n) |-> s_reset_low_hold)
		else $error("Reset pin released before its least low time.");

	a_reset_high_read: assert property ($rose(pins_q.reset_n) |-> s_no_read_after_release)
		else $error("Read started too soon after reset release.");

	a_elev_setup_write: assert property (pins_q.reset_hv && $fell(pins_q.we_n)
		|-> elev_age_q >= 6'(ELEV_SETUP_CYC))
		else $error("Write issued before elevated reset setup time.");

	a_protect_pulse_len: assert property ($rose(pins_q.we_n) && pins_q.prot_line_hv
		&& cmd_q.op == OP_PROTECT |-> wlen_q == PROT_PULSE_CYC && wlen_q >= PULSE_MIN_CYC)
		else $error("Protect write pulse has the wrong length.");

	a_unprot_pulse_len: assert property ($rose(pins_q.we_n) && pins_q.prot_line_hv
		&& cmd_q.op == OP_UNPROTECT |-> wlen_q == unprot_cyc && wlen_q >= PULSE_MIN_CYC)
		else $error("Unprotect write pulse has the wrong length.");

	a_erase_done_status: assert property (done_q && cmd_q.op == OP_ERASE
		|-> (cmd_q.use_toggle ? (stat_q[TOGGLE_STATUS_BIT] == prev_q[TOGGLE_STATUS_BIT])
		: stat_q[POLL_STATUS_BIT]) && !algo_q)
		else $error("Erase reported done without a finished status read.");

	a_poll_read_addr: assert property (!pins_q.oe_n && cmd_q.op == OP_ERASE
		&& !cmd_q.use_toggle |-> pins_q.addr[SECTOR_SELECT_HIGH_BIT:SECTOR_SELECT_LOW_BIT]
		== cmd_q.sector)
		else $error("Data polling read outside the erased sector.");

endmodule : flash_erase_host

// ==== testbench/flash_dev_model.sv ====
// Behavioural flash device: sector erase, status reads, reset pin and timing probes.
// Assumes the host pin struct of the package; every delay here is in ns.
module flash_dev_model (
	input wire flash_host_pkg::flash_pins_s pins_i,
	input wire logic [31:0] erase_ns_i,
	output logic [15:0] dq_o,
	output logic ready_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import flash_host_pkg::*;
	// ----------------------------------------------------------------------
	// State and host timing probes.
	// ----------------------------------------------------------------------
	logic busy = 1'b0; // An erase is running.
	logic tog = 1'b0; // Toggle bit value.
	logic [15:0] rd_val = 16'h0000; // Word shown during a read.
	logic [15:0] last = 16'h0000; // Last word shown.
	logic [17:0] rd_addr = 18'h00000; // Address of the last read.
	int step = 0; // Position within the erase sequence.
	int job = 0; // Bumps on each start or abort so stale finishes are dropped.
	int aborts = 0; // Erases lost to the reset pin.
	int viol = 0; // Host timing breaches seen.
	time t_rf = 0, t_rr = 0, t_hv = 0, t_wf = 0;
	logic sel_w = 1'b0; // Chip enable was low as the write strobe fell.
	int sect_q[$]; // Sectors whose erase finished.
	int rst_w[$]; // Reset low widths in ns.
	int pulse_w[$]; // Protect and unprotect write pulse widths in ns.
	wire rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.reset_n;
	// Released data lines show the inverse of the last word, so stale data never passes.
	assign dq_o = rd ? rd_val : (!pins_i.dq_oe_n ? pins_i.dq_out : ~last);
	initial ready_pin_o = 1'b1;

	// Ends an algorithm after a delay unless a newer start or abort came first.
	task automatic settle(input int d, input int j, input int sec);
		fork
			begin
				#(d);
				if (job == j)
				begin
					busy = 1'b0;
					ready_pin_o = 1'b1;
					if (sec >= 0) sect_q.push_back(sec);
				end
			end
		join_none
	endtask : settle

	// A read latches the status word while busy and erased data when idle.
	always @(posedge rd)
	begin
		if ($time - t_rr < RESET_HIGH_BEFORE_READ_NS) viol++;
		rd_addr = pins_i.addr;
		if (busy)
		begin
			tog = ~tog;
			rd_val = {8'h00, 1'b0, tog, 6'h00};
		end
		else
			rd_val = 16'hffff;
		last = rd_val;
	end

	// The host may lift chip enable with the write strobe, so enable is taken at the fall.
	always @(negedge pins_i.we_n)
	begin
		t_wf = $time;
		sel_w = (pins_i.ce_n === 1'b0);
	end
	always @(posedge pins_i.reset_hv) t_hv = $time;

	// Writes are taken on the rising write strobe; six in order start an erase.
	always @(posedge pins_i.we_n)
	begin
		if (sel_w && pins_i.reset_n && pins_i.prot_line_hv)
			pulse_w.push_back(int'($time - t_wf));
		else if (sel_w && pins_i.reset_n)
		begin
			if (pins_i.reset_hv && $time - t_hv < UNPROTECT_RESET_SETUP_NS) viol++;
			if (step < 5 && pins_i.addr == ERASE_ADDR[step] && pins_i.dq_out == ERASE_DATA[step])
				step++;
			else if (step == 5 && pins_i.addr[11:0] == 12'h000 && pins_i.dq_out == ERASE_DATA[5])
			begin
				step = 0;
				busy = 1'b1;
				ready_pin_o = 1'b0;
				job++;
				settle(int'(erase_ns_i), job, int'(pins_i.addr[17:12]));
			end
			else
				step = 0;
		end
	end

	// The reset pin abandons a running erase and recovers well inside the limit.
	always @(negedge pins_i.reset_n)
	begin
		t_rf = $time;
		step = 0;
		if (busy)
		begin
			aborts++;
			job++;
			settle(2000, job, -1);
		end
	end

	always @(posedge pins_i.reset_n)
	begin
		t_rr = $time;
		if (t_rf > 0) rst_w.push_back(int'($time - t_rf));
	end
endmodule : flash_dev_model

// ==== testbench/flash_erase_status_reset_bench.sv ====
// Self-checking bench for the flash erase host against a behavioural flash device.
// Assumes the package constants, a 10 MHz clock and the device model beside it.
module flash_erase_status_reset_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_host_pkg::*;
	localparam int UNPROT_CYC = 20; // Short unprotect pulse for simulation.
	localparam int LIMIT = 20000; // Run ceiling in cycles.
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_s cmd = '0;
	logic [31:0] erase_ns = 32'd3000;
	wire logic [15:0] dq;
	wire logic rdy_pin;
	flash_pins_s flash;
	logic busy, done, ready;
	logic [15:0] status;
	int num_errors = 0, compares = 0, cycles = 0, c = 0;
	int seed = 32'h3ddb;
	int exp_q[$]; // Sectors the bench expects to be erased, in order.

	flash_erase_host #(.UNPROT_PULSE_CYC(UNPROT_CYC)) u_flash_erase_host (
		.core_clk_i(core_clk), .nrst_i(nrst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.dq_i(dq), .algorithm_done_output_i(rdy_pin), .flash_o(flash), .busy_o(busy),
		.done_o(done), .status_o(status), .ready_o(ready));
	flash_dev_model u_flash_dev_model (.pins_i(flash), .erase_ns_i(erase_ns), .dq_o(dq),
		.ready_pin_o(rdy_pin));

	always #50 core_clk = ~core_clk;

	// ----------------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------------
	task automatic print_verdict();
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Holds a request for a number of edges; only the first can be taken.
	task automatic run_cmd(input op_e op, input logic [5:0] sec, input logic tg, input int hold);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, sector: sec, use_toggle: tg};
		repeat (hold) @(posedge core_clk);
		cmd_valid <= 1'b0;
		c = 0;
		while (done !== 1'b1 && c < 3000)
		begin
			@(posedge core_clk);
			c++;
		end
		check(c < 3000, 1'b1);
	endtask : run_cmd

	// Random sector and erase time; checks busy state mid-way and status at the end.
	task automatic erase(input logic tg, input int hold);
		logic [5:0] sec;
		sec = 6'($random(seed));
		erase_ns <= 32'(2000 + ($random(seed) & 32'h0fff));
		exp_q.push_back(int'(sec));
		fork
			run_cmd(OP_ERASE, sec, tg, hold);
			begin
				repeat (20) @(posedge core_clk);
				check(busy, 1'b1);
				check(ready, 1'b0);
			end
		join
		check(status[POLL_STATUS_BIT], 1'b1);
		check(u_flash_dev_model.rd_addr, tg ? 18'h00000 : {sec, 12'h000});
		repeat (6) @(posedge core_clk);
		check(ready, 1'b1);
	endtask : erase

	// A hang ends the run as a failure.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			num_errors++;
			$display("MISMATCH %0t run too long", $time);
			print_verdict();
		end
	end

	// ----------------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		// Repeated requests while busy must not start a second erase.
		erase(1'b0, 3);
		for (int i = 0; i < 4; i++)
			erase(i[0], 1);
		// Temporary unprotect with an erase inside it.
		run_cmd(OP_TEMP_ENTER, 6'h00, 1'b0, 1);
		check(flash.reset_hv, 1'b1);
		check(c >= ELEV_SETUP_CYC, 1'b1);
		erase(1'b1, 1);
		run_cmd(OP_TEMP_EXIT, 6'h00, 1'b0, 1);
		check(flash.reset_hv, 1'b0);
		// Reset pin with no algorithm running recovers quickly.
		run_cmd(OP_RESET, 6'h00, 1'b0, 1);
		check(c < 40, 1'b1);
		check(u_flash_dev_model.rst_w[$], RST_PULSE_CYC * CLK_PERIOD_NS);
		// High-voltage write pulses.
		run_cmd(OP_PROTECT, 6'h2a, 1'b0, 1);
		check(u_flash_dev_model.pulse_w[$], PROT_PULSE_CYC * CLK_PERIOD_NS);
		run_cmd(OP_UNPROTECT, 6'h15, 1'b0, 1);
		check(u_flash_dev_model.pulse_w[$], UNPROT_CYC * CLK_PERIOD_NS);
		// Host restarts while the device erases; the reset pin then abandons the erase.
		erase_ns <= 32'd100000;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: OP_ERASE, sector: 6'h33, use_toggle: 1'b0};
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		repeat (30) @(posedge core_clk);
		check(busy, 1'b1);
		nrst <= 1'b0;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (6) @(posedge core_clk);
		check(ready, 1'b0);
		run_cmd(OP_RESET, 6'h00, 1'b0, 1);
		check(c >= READY_ALGO_CYC, 1'b1);
		check(ready, 1'b1);
		check(u_flash_dev_model.aborts, 1);
		check(u_flash_dev_model.rst_w[$] >= RESET_PULSE_MIN_NS, 1'b1);
		erase(1'b0, 1);
		check(u_flash_dev_model.sect_q.size(), exp_q.size());
		foreach (exp_q[i])
			check(u_flash_dev_model.sect_q[i], exp_q[i]);
		check(u_flash_dev_model.viol, 0);
		print_verdict();
	end
endmodule : flash_erase_status_reset_bench
